// ### hdl/irq_agg_pkg.sv
// Register map, field positions and constants of the host interrupt aggregator.
package irq_agg_pkg;
	localparam int ADDR_W = 9;
	localparam logic [8:0] OFF_FIFO_FAULT_STATUS = 9'h1C8;
	localparam logic [8:0] OFF_FIFO_FAULT_MASK = 9'h1CC;
	localparam logic [8:0] OFF_TX_ROLL_STATUS = 9'h1D0;
	localparam logic [8:0] OFF_TX_ROLL_MASK = 9'h1D4;
	localparam logic [8:0] OFF_RX_ROLL_STATUS = 9'h1D8;
	localparam logic [8:0] OFF_RX_ROLL_MASK = 9'h1DC;
	localparam logic [8:0] OFF_TOP_STATUS = 9'h1E8;
	localparam logic [8:0] OFF_TOP_MASK = 9'h1EC;
	localparam logic [31:0] RST_VAL = 32'h00000000;
	localparam logic [31:0] FIFO_FAULT_VALID = 32'hCCCCCCCC;
	localparam int BIT_WAKE = 20;
	localparam int BIT_QSTAT = 19;
	localparam int BIT_FIFO_FAULT = 18;
	localparam int BIT_PHY = 17;
	localparam int BIT_ROLL = 16;
	localparam int BIT_TX_BAD = 12;
	localparam int BIT_RX_BAD = 11;
	localparam int BIT_LATE_RX = 8;
	localparam int BIT_EARLY_RX = 7;
	localparam int BIT_LATE_TX = 5;
	localparam int BIT_EARLY_TX = 4;
	localparam int BIT_WATERMARK = 3;
	localparam int BIT_NO_MEM = 2;
	localparam int BIT_PAUSE = 1;
	localparam int BIT_CLASS = 0;
	localparam logic [15:0] EVENT_VALID = 16'h19BF;
	localparam logic [4:0] PHY_MGMT_ADDRESS = 5'h01;
endpackage : irq_agg_pkg

// ### hdl/host_interrupt_aggregator.sv
// Host interrupt aggregator: source status, masks, top status and the interrupt output.
`timescale 1ns/1ns
// Contract
// - Fault mask bit forwards matching fifo fault status bit to top status.
// - Tx rollover bit n sets on tx counter n rollover; clears on read.
// - Tx rollover mask bit forwards matching tx rollover bit upward.
// - Rx rollover bit n sets on counter n+32 rollover; clears on read.
// - Rx rollover mask bit forwards matching rx rollover bit upward.
// - Top bit 20 shows the active-low power event input asserted.
// - Top bits 19..16 are summaries, follow sources, not cleared by read.
// - Top bits 15..0 are event flags cleared by reading top status.
// - Top bit 12 sets when a transmitted frame ended with error.
// - Top bit 11 sets when a frame was received with error.
// - Top bit 8 sets when a complete frame joins the receive queue.
// - Top bit 7 sets on start of reception.
// - Top bit 5 sets on transmission completion.
// - Top bit 4 sets on transmission start.
// - Top bit 3 sets when free block count hits low watermark.
// - Top bit 2 sets when a queue requests memory and none is free.
// - Top bit 1 sets when local pause turns on or off.
// - Top bit 0 sets on a packet classification event.
// - Top mask bit lets matching top status bit drive the interrupt.
// - Unsupported PHY management registers read as zero (outside this block).
// - PHY answers only management address 00001b (outside this block).
module host_interrupt_aggregator (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [8:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	input wire logic [31:0] fifo_fault_event,
	input wire logic [31:0] tx_roll_event,
	input wire logic [31:0] rx_roll_event,
	input wire logic queue_state_pending,
	input wire logic phy_irq,
	input wire logic power_event_n,
	input wire logic [15:0] event_pulse,
	output logic irq
);
	logic [31:0] ff_stat_r;
	logic [31:0] ff_mask_r;
	logic [31:0] tx_stat_r;
	logic [31:0] tx_mask_r;
	logic [31:0] rx_stat_r;
	logic [31:0] rx_mask_r;
	logic [15:0] evt_r;
	logic [4:0] sum_r;
	logic [31:0] top_mask_r;
	logic [31:0] top_nxt;
	logic rd_ff;
	logic rd_tx;
	logic rd_rx;
	logic rd_top;

	assign rd_ff = reg_rd && reg_addr == irq_agg_pkg::OFF_FIFO_FAULT_STATUS;
	assign rd_tx = reg_rd && reg_addr == irq_agg_pkg::OFF_TX_ROLL_STATUS;
	assign rd_rx = reg_rd && reg_addr == irq_agg_pkg::OFF_RX_ROLL_STATUS;
	assign rd_top = reg_rd && reg_addr == irq_agg_pkg::OFF_TOP_STATUS;

	// Sticky source bits; a new event wins over a clearing read in the same cycle.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ff_stat_r <= irq_agg_pkg::RST_VAL;
			tx_stat_r <= irq_agg_pkg::RST_VAL;
			rx_stat_r <= irq_agg_pkg::RST_VAL;
		end else begin
			ff_stat_r <= ((rd_ff ? 32'h0 : ff_stat_r) | fifo_fault_event)
				& irq_agg_pkg::FIFO_FAULT_VALID;
			tx_stat_r <= (rd_tx ? 32'h0 : tx_stat_r) | tx_roll_event;
			rx_stat_r <= (rd_rx ? 32'h0 : rx_stat_r) | rx_roll_event;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ff_mask_r <= irq_agg_pkg::RST_VAL;
			tx_mask_r <= irq_agg_pkg::RST_VAL;
			rx_mask_r <= irq_agg_pkg::RST_VAL;
			top_mask_r <= irq_agg_pkg::RST_VAL;
		end else if (reg_wr) begin
			case (reg_addr)
				irq_agg_pkg::OFF_FIFO_FAULT_MASK: ff_mask_r <= reg_wdata;
				irq_agg_pkg::OFF_TX_ROLL_MASK: tx_mask_r <= reg_wdata;
				irq_agg_pkg::OFF_RX_ROLL_MASK: rx_mask_r <= reg_wdata;
				irq_agg_pkg::OFF_TOP_MASK: top_mask_r <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Event flags, cleared by reading the top status; a same-cycle event survives.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			evt_r <= 16'h0000;
		end else begin
			// Bits 12,11,8,7,5,4,3,2,1,0 as wired on event_pulse.
			evt_r <= ((rd_top ? 16'h0000 : evt_r) | event_pulse)
				& irq_agg_pkg::EVENT_VALID;
		end
	end

	// Summary bits are registered copies of their sources; reads leave them alone.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			sum_r <= 5'h00;
		end else begin
			sum_r[4] <= !power_event_n;
			sum_r[3] <= queue_state_pending;
			sum_r[2] <= |(ff_stat_r & ff_mask_r);
			sum_r[1] <= phy_irq;
			sum_r[0] <= |(tx_stat_r & tx_mask_r) | |(rx_stat_r & rx_mask_r);
		end
	end

	assign top_nxt = {11'h000, sum_r, evt_r};

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(top_nxt & top_mask_r);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				irq_agg_pkg::OFF_FIFO_FAULT_STATUS: reg_rdata <= ff_stat_r;
				irq_agg_pkg::OFF_FIFO_FAULT_MASK: reg_rdata <= ff_mask_r;
				irq_agg_pkg::OFF_TX_ROLL_STATUS: reg_rdata <= tx_stat_r;
				irq_agg_pkg::OFF_TX_ROLL_MASK: reg_rdata <= tx_mask_r;
				irq_agg_pkg::OFF_RX_ROLL_STATUS: reg_rdata <= rx_stat_r;
				irq_agg_pkg::OFF_RX_ROLL_MASK: reg_rdata <= rx_mask_r;
				irq_agg_pkg::OFF_TOP_STATUS: reg_rdata <= top_nxt;
				irq_agg_pkg::OFF_TOP_MASK: reg_rdata <= top_mask_r;
				default: reg_rdata <= 32'h00000000;
			endcase
		end
	end

	AST_TX_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(tx_roll_event[0] |=> tx_stat_r[0])) else $error("tx rollover not set");
	AST_TX_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd_tx && tx_roll_event == 32'h0 |=> tx_stat_r == 32'h0))
		else $error("tx rollover not cleared");
	AST_RX_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd_rx && rx_roll_event == 32'h0 |=> rx_stat_r == 32'h0))
		else $error("rx rollover not cleared");
	AST_FF_FWD: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(|(ff_stat_r & ff_mask_r) |=> sum_r[2])) else $error("fault not forwarded");
	AST_ROLL_BLOCK: assert property (@(posedge sys_clk) disable iff (!rst_n)
		((tx_mask_r == 32'h0 && rx_mask_r == 32'h0) |=> !sum_r[0]))
		else $error("masked rollover forwarded");
	AST_WAKE: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!power_event_n ##1 !power_event_n |=> sum_r[4])) else $error("wake missing");
	AST_EVT_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd_top && event_pulse == 16'h0 |=> evt_r == 16'h0))
		else $error("event flags not cleared");
	AST_SUM_KEEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd_top && phy_irq |=> sum_r[1])) else $error("summary cleared by read");
	AST_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(|(top_nxt & top_mask_r) |=> irq)) else $error("irq not raised");
	AST_IRQ_MASK: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(top_mask_r == 32'h0 |=> !irq)) else $error("masked irq raised");

	// An enabled rollover bit reaches the summary bit on the next edge.
	sequence roll_enabled_s;
		|(tx_stat_r & tx_mask_r) || |(rx_stat_r & rx_mask_r);
	endsequence

	// A classification event with its mask held set for two cycles.
	sequence class_evt_enabled_s;
		(event_pulse[irq_agg_pkg::BIT_CLASS] && top_mask_r[irq_agg_pkg::BIT_CLASS])
			##1 top_mask_r[irq_agg_pkg::BIT_CLASS];
	endsequence

	AST_ROLL_FWD: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(roll_enabled_s |=> sum_r[0])) else $error("rollover not forwarded");
	AST_CLASS_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(event_pulse[0] |=> evt_r[0])) else $error("class flag not set");
	AST_CLASS_IRQ: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(class_evt_enabled_s |=> irq)) else $error("class event lost on irq");
	AST_FF_CLR: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(rd_ff && fifo_fault_event == 32'h00000000 |=> ff_stat_r == 32'h00000000))
		else $error("fault status not cleared");
	AST_TX_BAD_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(event_pulse[irq_agg_pkg::BIT_TX_BAD] |=> evt_r[irq_agg_pkg::BIT_TX_BAD]))
		else $error("tx bad flag not set");
endmodule : host_interrupt_aggregator

// ### test/host_model.sv
// Host processor model driving the register strobes of the device.
`timescale 1ns/1ns
module host_model (
	input wire logic sys_clk,
	output logic reg_rd = 1'b0,
	output logic reg_wr = 1'b0,
	output logic [8:0] reg_addr = 9'h000,
	output logic [31:0] reg_wdata = 32'h00000000
);
	// Released lines show the inverse so a stale value is never mistaken for a live one.
	task automatic rd(input logic [8:0] a);
		@(posedge sys_clk);
		{reg_rd, reg_addr} <= {1'b1, a};
		@(posedge sys_clk);
		{reg_rd, reg_addr} <= {1'b0, ~a};
	endtask : rd
	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge sys_clk);
		{reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
	endtask : wr
endmodule : host_model

// ### test/test_host_interrupt_aggregator.sv
// Self-checking bench for the host interrupt aggregator.
`timescale 1ns/1ns
module test_host_interrupt_aggregator;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic qsp = 1'b0;
	logic phy = 1'b0;
	logic pwr_n = 1'b1;
	logic reg_rd, reg_wr, irq;
	logic [8:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [31:0] ff_ev = 32'h0, tx_ev = 32'h0, rx_ev = 32'h0;
	logic [15:0] ev_p = 16'h0;
	int failures = 0;
	int compares = 0;
	int cyc = 0;
	host_model host (.sys_clk(sys_clk), .reg_rd(reg_rd), .reg_wr(reg_wr),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	host_interrupt_aggregator dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.fifo_fault_event(ff_ev), .tx_roll_event(tx_ev), .rx_roll_event(rx_ev),
		.queue_state_pending(qsp), .phy_irq(phy), .power_event_n(pwr_n),
		.event_pulse(ev_p), .irq(irq));
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			failures++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rdc(input logic [8:0] a, input logic [31:0] e);
		host.rd(a);
		#1 chk("reg_rdata", e, reg_rdata);
	endtask : rdc
	task automatic irqc(input logic e);
		@(posedge sys_clk);
		#1 chk("irq", {31'h0, e}, {31'h0, irq});
	endtask : irqc
	task automatic pulse(input logic [31:0] f, t, r, input logic [15:0] e);
		@(posedge sys_clk);
		{ff_ev, tx_ev, rx_ev, ev_p} <= {f, t, r, e};
		@(posedge sys_clk);
		{ff_ev, tx_ev, rx_ev, ev_p} <= '0;
	endtask : pulse
	task automatic t_regs();
		logic [8:0] m [4] = '{9'h1CC, 9'h1D4, 9'h1DC, 9'h1EC};
		foreach (m[i]) rdc(m[i], 32'h0);
		rdc(9'h1E0, 32'h0);
		foreach (m[i]) begin
			host.wr(m[i], 32'hA5A5A5A5 ^ 32'(i));
			rdc(m[i], 32'hA5A5A5A5 ^ 32'(i));
		end
		host.wr(9'h1D0, 32'hFFFFFFFF);
		rdc(9'h1D0, 32'h0);
	endtask : t_regs
	task automatic t_events();
		host.wr(9'h1EC, 32'h0);
		pulse(0, 0, 0, 16'hFFFF);
		irqc(1'b0);
		rdc(9'h1E8, 32'h000019BF);
		rdc(9'h1E8, 32'h0);
		host.wr(9'h1EC, 32'h00000001);
		pulse(0, 0, 0, 16'h0001);
		irqc(1'b1);
		rdc(9'h1E8, 32'h00000001);
		irqc(1'b0);
	endtask : t_events
	task automatic t_roll();
		host.wr(9'h1D4, 32'h00000020);
		host.wr(9'h1DC, 32'h80000000);
		host.wr(9'h1EC, 32'h00010000);
		pulse(0, 32'h00000002, 0, 0);
		rdc(9'h1E8, 32'h0);
		rdc(9'h1D0, 32'h00000002);
		pulse(0, 32'h00000021, 32'h80000001, 0);
		// The summary bit needs one more edge, the interrupt output another.
		@(posedge sys_clk);
		repeat (2) irqc(1'b1);
		rdc(9'h1E8, 32'h00010000);
		rdc(9'h1E8, 32'h00010000);
		rdc(9'h1D0, 32'h00000021);
		rdc(9'h1D0, 32'h0);
		rdc(9'h1D8, 32'h80000001);
		rdc(9'h1E8, 32'h0);
	endtask : t_roll
	task automatic t_summary();
		host.wr(9'h1CC, 32'hFFFFFFFF);
		pulse(32'hFFFFFFFF, 0, 0, 0);
		{pwr_n, phy, qsp} <= 3'b011;
		// Let the level inputs and the fault summary reach the summary bits.
		repeat (2) @(posedge sys_clk);
		rdc(9'h1E8, 32'h001E0000);
		rdc(9'h1C8, 32'hCCCCCCCC);
		{pwr_n, phy, qsp} <= 3'b100;
		rdc(9'h1E8, 32'h0);
	endtask : t_summary
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_regs();
		t_events();
		t_roll();
		t_summary();
		tally_and_finish();
	end
endmodule : test_host_interrupt_aggregator
